// [logic/crc16_generator_checker.sv]
// apb register slave and sequencer for the 16-bit crc generator and checker
// Functional notes
// - Remainder uses generator polynomial 0x1021, x^16+x^12+x^5+1.
// - Start value is whatever software wrote into both remainder bytes.
// - Input accepted as whole bytes in byte input, or single serial bits in control.
// - Without a loaded start value the remainder is zero.
// - Each byte input write alone starts one byte update.
// - Finished checksum is readable in the two remainder bytes.
// - Result-ok flag, control bit 1, is high exactly when remainder is zero.
// - Unaligned data goes through serial value and strobe bits.
// - Writing strobe as one folds serial value bit into remainder.
// - Byte and bit updates may be mixed freely, remainder carried over.
// - With strobe one, each control write does one bit step; else none.
// - Serial value at control bit 6, strobe at bit 5, both read/write.
// - Control resets to 0x02; remainder bytes and byte input reset to zero.
//
// Chosen here: the APB register port and the address map.
`timescale 1ns/1ns
module crc16_generator_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SHIFT = 2'b10
  } state_t;

  //////////////////////////////////////////////////////////////////////////////
  // state
  state_t state_q;
  logic [15:0] rem_q;
  logic [7:0] byte_q;
  logic [7:0] shift_q;
  logic [3:0] count_q;
  logic serial_value_q;
  logic serial_strobe_q;
  logic [crc_pkg::IRQ_WIDTH-1:0] irq_status_q;
  logic [crc_pkg::IRQ_WIDTH-1:0] irq_enable_q;
  logic [31:0] prdata_q;
  logic result_ok;
  logic busy;
  logic busy_q;
  logic [9:0] word_index;
  logic addr_ok;
  logic setup;
  logic wr_access;
  logic rd_access;
  logic wr_lane0;
  logic wr_ctrl;
  logic wr_byte;
  logic wr_low;
  logic wr_high;
  logic wr_irq_en;
  logic wr_irq_clr;
  logic ser_step;
  logic byte_last;
  logic [7:0] wdat;
  logic [7:0] ctrl_read;
  logic [7:0] rd_byte;
  logic [crc_pkg::IRQ_WIDTH-1:0] irq_events;

  //////////////////////////////////////////////////////////////////////////////
  // single-bit step instance, shared by serial and byte updates
  crc_step_if step_bus ();
  crc_bit_step u_step (
    .s(step_bus.step)
  );
  // feed the step: next byte bit msb first while shifting, else the serial bit
  assign step_bus.rem_in = rem_q;
  assign step_bus.bit_in = busy ? shift_q[7] : wdat[crc_pkg::BIT_SERIAL_VALUE];

  //////////////////////////////////////////////////////////////////////////////
  // apb decode; printed offsets are indices, byte address is four times index
  assign word_index = paddr[11:2];
  assign wdat = pwdata[7:0];
  assign busy = (state_q == ST_SHIFT);
  always_comb
  begin
    case (word_index[7:0])
      crc_pkg::IDX_CONTROL, crc_pkg::IDX_BYTE_IN, crc_pkg::IDX_REM_LOW, crc_pkg::IDX_REM_HIGH,
      crc_pkg::IDX_IRQ_STATUS, crc_pkg::IDX_IRQ_ENABLE, crc_pkg::IDX_IRQ_CLEAR:
        addr_ok = (word_index[9:8] == 2'b00) && (paddr[1:0] == 2'b00);
      default:
        addr_ok = 1'b0;
    endcase
  end
  // access waits while a byte update runs, and one cycle more so read data catches up
  assign pready = psel & penable & ~busy & ~busy_q;
  assign pslverr = pready & ~addr_ok;
  assign setup = pready & addr_ok;
  assign wr_access = setup & pwrite;
  assign rd_access = setup & ~pwrite;
  assign wr_lane0 = wr_access & pstrb[0];
  assign wr_ctrl = wr_lane0 && (word_index[7:0] == crc_pkg::IDX_CONTROL);
  assign wr_byte = wr_lane0 && (word_index[7:0] == crc_pkg::IDX_BYTE_IN);
  assign wr_low = wr_lane0 && (word_index[7:0] == crc_pkg::IDX_REM_LOW);
  assign wr_high = wr_lane0 && (word_index[7:0] == crc_pkg::IDX_REM_HIGH);
  assign wr_irq_en = wr_lane0 && (word_index[7:0] == crc_pkg::IDX_IRQ_ENABLE);
  assign wr_irq_clr = wr_lane0 && (word_index[7:0] == crc_pkg::IDX_IRQ_CLEAR);
  // a control write with the strobe set performs one bit step
  assign ser_step = wr_ctrl & wdat[crc_pkg::BIT_SERIAL_STROBE];

  //////////////////////////////////////////////////////////////////////////////
  // byte sequencer: eight bit steps, one per clock
  assign byte_last = busy && (count_q == 4'h1);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= ST_IDLE;
      count_q <= 4'h0;
      shift_q <= crc_pkg::RST_BYTE;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (wr_byte)
          begin
            state_q <= ST_SHIFT;
            count_q <= crc_pkg::BYTE_STEPS;
            shift_q <= wdat;
          end
        end
        ST_SHIFT:
        begin
          shift_q <= {shift_q[6:0], 1'b0};
          count_q <= count_q - 4'h1;
          if (byte_last)
            state_q <= ST_IDLE;
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // busy delayed by one cycle; holds off the access until read data is refreshed
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      busy_q <= 1'b0;
    else
      busy_q <= busy;
  end

  //////////////////////////////////////////////////////////////////////////////
  // remainder register: software load, byte steps and serial steps
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rem_q <= crc_pkg::RST_REMAINDER;
    else if (busy)
      rem_q <= step_bus.rem_out;
    else if (ser_step)
      rem_q <= step_bus.rem_out;
    else if (wr_low)
      rem_q[7:0] <= wdat;
    else if (wr_high)
      rem_q[15:8] <= wdat;
  end

  // byte input register keeps the last written byte for read back
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      byte_q <= crc_pkg::RST_BYTE;
    else if (wr_byte)
      byte_q <= wdat;
  end

  // serial value and strobe bits hold what software wrote
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      serial_value_q <= crc_pkg::RST_CONTROL[crc_pkg::BIT_SERIAL_VALUE];
      serial_strobe_q <= crc_pkg::RST_CONTROL[crc_pkg::BIT_SERIAL_STROBE];
    end
    else if (wr_ctrl)
    begin
      serial_value_q <= wdat[crc_pkg::BIT_SERIAL_VALUE];
      serial_strobe_q <= wdat[crc_pkg::BIT_SERIAL_STROBE];
    end
  end

  // result flag follows the remainder; finished checksum sits in rem_q
  assign result_ok = (rem_q == 16'h0000);

  //////////////////////////////////////////////////////////////////////////////
  // interrupts: sticky status, set wins over clear, enable gates the output
  assign irq_events[crc_pkg::IRQ_BYTE_DONE] = byte_last;
  assign irq_events[crc_pkg::IRQ_BIT_DONE] = ser_step;
  assign irq_events[crc_pkg::IRQ_RESULT_OK] = (byte_last || ser_step) && (step_bus.rem_out == 16'h0000);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_status_q <= '0;
    else
      irq_status_q <= (irq_status_q & ~(wr_irq_clr ? wdat[crc_pkg::IRQ_WIDTH-1:0] : '0)) | irq_events;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_enable_q <= '0;
    else if (wr_irq_en)
      irq_enable_q <= wdat[crc_pkg::IRQ_WIDTH-1:0];
  end
  assign irq = |(irq_status_q & irq_enable_q);

  //////////////////////////////////////////////////////////////////////////////
  // read mux and registered read data
  always_comb
  begin
    ctrl_read = 8'h00;
    ctrl_read[crc_pkg::BIT_SERIAL_VALUE] = serial_value_q;
    ctrl_read[crc_pkg::BIT_SERIAL_STROBE] = serial_strobe_q;
    ctrl_read[crc_pkg::BIT_RESULT_OK] = result_ok;
    case (word_index[7:0])
      crc_pkg::IDX_CONTROL: rd_byte = ctrl_read;
      crc_pkg::IDX_BYTE_IN: rd_byte = byte_q;
      crc_pkg::IDX_REM_LOW: rd_byte = rem_q[7:0];
      crc_pkg::IDX_REM_HIGH: rd_byte = rem_q[15:8];
      crc_pkg::IDX_IRQ_STATUS: rd_byte = {5'h00, irq_status_q};
      crc_pkg::IDX_IRQ_ENABLE: rd_byte = {5'h00, irq_enable_q};
      default: rd_byte = 8'h00;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= 32'h00000000;
    else if (psel && !rd_access)
      prdata_q <= {24'h000000, rd_byte}; // refreshed every cycle until the access completes
  end
  // read data only shown while the access completes
  assign prdata = rd_access ? prdata_q : 32'h00000000;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  result_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_read[crc_pkg::BIT_RESULT_OK] == (rem_q == 16'h0000))
    else $error("result flag disagrees with remainder");
  byte_eight_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_byte && !busy) |=> busy [*8] ##1 !busy)
    else $error("byte update not eight cycles");
  byte_trigger_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(busy) |-> $past(wr_byte))
    else $error("byte update without byte write");
  serial_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    ser_step |=> rem_q == ($past(rem_q[15]) ^ $past(wdat[crc_pkg::BIT_SERIAL_VALUE]) ?
      {$past(rem_q[14:0]), 1'b0} ^ crc_pkg::POLY : {$past(rem_q[14:0]), 1'b0}))
    else $error("serial step result wrong");
  no_strobe_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ctrl && !wdat[crc_pkg::BIT_SERIAL_STROBE]) |=> rem_q == $past(rem_q))
    else $error("remainder moved without strobe");
  load_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_low |=> rem_q[7:0] == $past(wdat))
    else $error("start value low byte not loaded");
  ctrl_bits_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctrl |=> serial_value_q == $past(wdat[crc_pkg::BIT_SERIAL_VALUE]) &&
      serial_strobe_q == $past(wdat[crc_pkg::BIT_SERIAL_STROBE]))
    else $error("control bits not stored");
  stall_busy_a: assert property (@(posedge pclk) disable iff (!presetn)
    busy |-> !pready)
    else $error("access completed during byte update");
  reset_zero_a: assert property (@(posedge pclk)
    !presetn |-> rem_q == 16'h0000 && byte_q == 8'h00)
    else $error("reset values wrong");
  // second remainder byte takes the written start value
  load_high_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_high |=> rem_q[15:8] == $past(wdat))
    else $error("start value high byte not loaded");
  // byte input register keeps the written byte
  byte_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_byte |=> byte_q == $past(wdat))
    else $error("byte input not stored");
  // each byte step folds the next byte bit, msb first
  byte_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    busy |=> rem_q == ($past(rem_q[15]) ^ $past(shift_q[7]) ?
      {$past(rem_q[14:0]), 1'b0} ^ crc_pkg::POLY : {$past(rem_q[14:0]), 1'b0}))
    else $error("byte step result wrong");
  // no register access completes during a byte update
  busy_access_a: assert property (@(posedge pclk) disable iff (!presetn)
    busy |-> !wr_access && !rd_access)
    else $error("access taken during byte update");
  // read data gets one more cycle after a byte update
  busy_tail_a: assert property (@(posedge pclk) disable iff (!presetn)
    busy_q |-> !pready)
    else $error("access taken right after byte update");
  // refused access leaves the calculation alone
  err_ignored_a: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |=> rem_q == $past(rem_q) && !busy)
    else $error("refused access changed the remainder");
  // write with lane zero off does nothing
  lane_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_access && !pstrb[0]) |=> rem_q == $past(rem_q) && !busy)
    else $error("masked write changed the remainder");
  // remainder holds while nothing updates it
  rem_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!busy && !ser_step && !wr_low && !wr_high) |=> rem_q == $past(rem_q))
    else $error("remainder moved without an update");
  // control register value while in reset
  reset_ctrl_a: assert property (@(posedge pclk)
    !presetn |-> ctrl_read == crc_pkg::RST_CONTROL)
    else $error("control reset value wrong");

  //////////////////////////////////////////////////////////////////////////////
  // read path and interrupt checks
  // read data shows the result flag of the current remainder
  result_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_access && word_index[7:0] == crc_pkg::IDX_CONTROL) |->
      prdata[crc_pkg::BIT_RESULT_OK] == (rem_q == 16'h0000))
    else $error("result flag read back wrong");
  // read data shows the current low remainder byte
  low_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_access && word_index[7:0] == crc_pkg::IDX_REM_LOW) |-> prdata[7:0] == rem_q[7:0])
    else $error("low remainder read back wrong");
  // read data shows the current high remainder byte
  high_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_access && word_index[7:0] == crc_pkg::IDX_REM_HIGH) |-> prdata[7:0] == rem_q[15:8])
    else $error("high remainder read back wrong");
  // read data is zero outside a completing read
  read_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    !rd_access |-> prdata == 32'h00000000)
    else $error("read data shown outside a read");
  // end of a byte update sets its status bit
  byte_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
    byte_last |=> irq_status_q[crc_pkg::IRQ_BYTE_DONE])
    else $error("byte done status not set");
  // serial step sets its status bit
  bit_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
    ser_step |=> irq_status_q[crc_pkg::IRQ_BIT_DONE])
    else $error("bit done status not set");
  // clear write drops a status bit when no new event comes
  clear_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_irq_clr && wdat[crc_pkg::IRQ_BYTE_DONE]) |=> !irq_status_q[crc_pkg::IRQ_BYTE_DONE])
    else $error("byte done status not cleared");

endmodule // crc16_generator_checker

// [logic/crc_bit_step.sv]
// one single-bit crc step, combinational
`timescale 1ns/1ns
module crc_bit_step (
  crc_step_if.step s
);
  logic fb;
  // feed back the xor of input and remainder msb, then shift and fold polynomial
  assign fb = s.bit_in ^ s.rem_in[15];
  assign s.rem_out = fb ? ({s.rem_in[14:0], 1'b0} ^ crc_pkg::POLY) : {s.rem_in[14:0], 1'b0};
endmodule // crc_bit_step

// [logic/crc_pkg.sv]
// package with register map, field positions and reset values of the crc block
package crc_pkg;
  // register word indices: printed offsets are not word aligned, so they are indices
  localparam logic [7:0] IDX_CONTROL = 8'hA9;
  localparam logic [7:0] IDX_BYTE_IN = 8'hAA;
  localparam logic [7:0] IDX_REM_LOW = 8'hAC;
  localparam logic [7:0] IDX_REM_HIGH = 8'hAD;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hB0;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'hB1;
  localparam logic [7:0] IDX_IRQ_CLEAR = 8'hB2;
  // control register fields
  localparam int BIT_SERIAL_VALUE = 6;
  localparam int BIT_SERIAL_STROBE = 5;
  localparam int BIT_RESULT_OK = 1;
  // reset values
  localparam logic [7:0] RST_CONTROL = 8'h02;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_REMAINDER = 16'h0000;
  // generator polynomial x^16 + x^12 + x^5 + 1
  localparam logic [15:0] POLY = 16'h1021;
  // interrupt status bits
  localparam int IRQ_BYTE_DONE = 0;
  localparam int IRQ_BIT_DONE = 1;
  localparam int IRQ_RESULT_OK = 2;
  localparam int IRQ_WIDTH = 3;
  // cycles taken by one byte update
  localparam logic [3:0] BYTE_STEPS = 4'h8;
endpackage

// [logic/crc_step_if.sv]
// interface carrying one single-bit step request and its result
`timescale 1ns/1ns
interface crc_step_if;
  logic [15:0] rem_in;
  logic bit_in;
  logic [15:0] rem_out;
  modport core (output rem_in, output bit_in, input rem_out);
  modport step (input rem_in, input bit_in, output rem_out);
endinterface

// [test/crc_core_model.sv]
// partner model: the core side, an apb master issuing register transfers
`timescale 1ns/1ns
module crc_core_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  ////////////////////////////////////////////////////////////
  // bus idle at time zero
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    pstrb = 4'hF;
  end
  // one transfer, held until pready is seen high at a rising edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
    output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50)
    begin
      @(posedge pclk);
      n++;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a; // released lines show no stale value
    pwdata <= ~d;
    if (n >= 50)
    begin
      tb.n_errors++;
      tb.final_report();
    end
  endtask
  ////////////////////////////////////////////////////////////
  // register write and read by index
  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    xfer(1'b1, {2'b00, i, 2'b00}, d, 4'hF, r, e);
  endtask
  task automatic rd(input logic [7:0] i, output logic [31:0] r);
    logic e;
    xfer(1'b0, {2'b00, i, 2'b00}, 32'h00000000, 4'hF, r, e);
  endtask
  // start value into both remainder bytes
  task automatic load_start(input logic [15:0] v);
    wr(crc_pkg::IDX_REM_LOW, {24'h000000, v[7:0]});
    wr(crc_pkg::IDX_REM_HIGH, {24'h000000, v[15:8]});
  endtask
  // one message byte, same order for generation and checking
  task automatic send_byte(input logic [7:0] b);
    wr(crc_pkg::IDX_BYTE_IN, {24'h000000, b});
  endtask
  // received checksum, high byte first
  task automatic send_check(input logic [15:0] c);
    send_byte(c[15:8]);
    send_byte(c[7:0]);
  endtask
  // one stream bit with the strobe set
  task automatic send_bit(input logic b);
    wr(crc_pkg::IDX_CONTROL, {25'h0000000, b, 1'b1, 5'h00});
  endtask
endmodule // crc_core_model

// [test/tb.sv]
// testbench for the crc generator and checker
`timescale 1ns/1ns
module tb;
  localparam logic [7:0] CT = crc_pkg::IDX_CONTROL;
  localparam logic [7:0] RL = crc_pkg::IDX_REM_LOW;
  localparam logic [7:0] RH = crc_pkg::IDX_REM_HIGH;
  localparam logic [7:0] IS = crc_pkg::IDX_IRQ_STATUS;
  localparam logic [7:0] IE = crc_pkg::IDX_IRQ_ENABLE;
  localparam logic [7:0] IC = crc_pkg::IDX_IRQ_CLEAR;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0] pstrb;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  int n_errors;
  int checked;
  logic [15:0] e;
  logic [31:0] v;
  logic er;
  ////////////////////////////////////////////////////////////
  crc16_generator_checker dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq));
  crc_core_model m (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // 10 mhz clock
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////
  // compare one value
  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
    checked++;
    if (g !== x)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", s, x, g);
    end
  endtask
  task automatic rc(input string s, input logic [7:0] i, input logic [31:0] x);
    logic [31:0] r;
    m.rd(i, r);
    chk(s, x, r);
  endtask
  // expected remainder after one bit and after one byte, msb first
  function automatic logic [15:0] f_bit(input logic [15:0] r, input logic b);
    f_bit = {r[14:0], 1'b0} ^ ((b ^ r[15]) ? crc_pkg::POLY : 16'h0000);
  endfunction
  function automatic logic [15:0] f_byte(input logic [15:0] r, input logic [7:0] d);
    f_byte = r;
    for (int i = 7; i >= 0; i--)
      f_byte = f_bit(f_byte, d[i]);
  endfunction
  task automatic rem(input logic [15:0] x);
    rc("rem_low", RL, {24'h000000, x[7:0]});
    rc("rem_high", RH, {24'h000000, x[15:8]});
  endtask
  ////////////////////////////////////////////////////////////
  // reset values, then one byte from the default start
  task t_reset;
    rc("control", CT, 32'h00000002);
    rc("byte_in", crc_pkg::IDX_BYTE_IN, 32'h00000000);
    rem(16'h0000);
    rc("irq_status", IS, 32'h00000000);
    m.send_byte(8'hA5);
    rem(f_byte(16'h0000, 8'hA5));
  endtask
  // generation over back-to-back bytes, then checking the same message
  task t_gen;
    m.load_start(16'h1D0F);
    e = 16'h1D0F;
    for (int i = 0; i < 3; i++)
    begin
      m.send_byte(8'h31 + 8'(i));
      e = f_byte(e, 8'h31 + 8'(i));
    end
    rem(e);
    rc("control", CT, {30'h00000000, e == 16'h0000, 1'b0});
    m.load_start(16'h1D0F);
    for (int i = 0; i < 3; i++)
      m.send_byte(8'h31 + 8'(i));
    m.send_check(e);
    rc("control", CT, 32'h00000002);
    rem(16'h0000);
  endtask
  // two bytes then two bits, then a write with the strobe low
  task t_serial;
    m.load_start(16'hBEEF);
    m.send_byte(8'h12);
    m.send_byte(8'h34);
    m.send_bit(1'b1);
    m.send_bit(1'b0);
    e = f_bit(f_bit(f_byte(f_byte(16'hBEEF, 8'h12), 8'h34), 1'b1), 1'b0);
    rem(e);
    m.wr(CT, 32'h00000040);
    rem(e);
    rc("control", CT, {25'h0000000, 2'b10, 3'h0, e == 16'h0000, 1'b0});
    m.send_bit(1'b1);
    e = f_bit(e, 1'b1);
    rc("control", CT, {25'h0000000, 2'b11, 3'h0, e == 16'h0000, 1'b0});
    rem(e);
    rc("irq_status", IS, 32'h00000007);
  endtask
  // interrupt raised, masked and cleared; refused addresses
  task t_irq;
    m.wr(IC, 32'h00000007);
    m.wr(IE, 32'h00000001);
    m.send_byte(8'h5A);
    e = f_byte(e, 8'h5A);
    rc("irq_status", IS, {29'h00000000, e == 16'h0000, 2'b01});
    @(negedge pclk);
    chk("irq", 32'h00000001, {31'h00000000, irq});
    m.wr(IE, 32'h00000000);
    @(negedge pclk);
    chk("irq", 32'h00000000, {31'h00000000, irq});
    m.wr(IC, 32'h00000007);
    rc("irq_status", IS, 32'h00000000);
    rc("irq_clear", IC, 32'h00000000);
    m.xfer(1'b1, 12'h000, 32'h00000000, 4'hF, v, er);
    chk("unmapped_err", 32'h00000001, {31'h00000000, er});
    m.xfer(1'b0, 12'h2A5, 32'h00000000, 4'hF, v, er);
    chk("misaligned_err", 32'h00000001, {31'h00000000, er});
    m.xfer(1'b0, 12'hEA4, 32'h00000000, 4'hF, v, er);
    chk("high_addr_err", 32'h00000001, {31'h00000000, er});
    m.xfer(1'b1, {2'b00, crc_pkg::IDX_BYTE_IN, 2'b00}, 32'h000000C3, 4'hE, v, er);
    chk("lane_off_err", 32'h00000000, {31'h00000000, er});
    rc("byte_in", crc_pkg::IDX_BYTE_IN, 32'h0000005A);
    rc("irq_status", IS, 32'h00000000);
    rem(e);
  endtask
  // reset in mid-run while a byte update runs and an interrupt stands
  task t_midreset;
    m.wr(IE, 32'h00000007);
    m.send_bit(1'b0);
    m.send_byte(8'hC3);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("irq", 32'h00000000, {31'h00000000, irq});
    rc("control", CT, 32'h00000002);
    rc("byte_in", crc_pkg::IDX_BYTE_IN, 32'h00000000);
    rem(16'h0000);
    rc("irq_status", IS, 32'h00000000);
    rc("irq_enable", IE, 32'h00000000);
    m.send_bit(1'b1);
    rem(f_bit(16'h0000, 1'b1));
  endtask
  ////////////////////////////////////////////////////////////
  // verdict and end of run
  task final_report;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
    begin
      $display("RESULT: PASS");
    end
    else
    begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // reset for three cycles, then the scenarios
  initial
  begin
    presetn = 1'b0;
    n_errors = 0;
    checked = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_gen;
    t_serial;
    t_irq;
    t_midreset;
    final_report;
  end
endmodule // tb
